// file: verilog/ref_switch_pkg.sv
// Purpose: shared constants for the reference input switch
// Assumes: 8-bit register port, two reference inputs
// Notes:   reset values are the register defaults
package ref_switch_pkg;

	// ----------------------------------------------------------------
	// register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_INPUT_PRIORITY = 8'h34;
	localparam logic [7:0] ADDR_SWITCH_MODE    = 8'h35;
	localparam logic [7:0] ADDR_HOLDOFF_PERIOD = 8'h36;
	localparam logic [7:0] ADDR_HOLDOFF_RANGE  = 8'h37;
	localparam logic [7:0] ADDR_SWITCH_STATUS  = 8'h38;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] RST_INPUT_PRIORITY = 8'he0;
	localparam logic [7:0] RST_SWITCH_MODE    = 8'h00;
	localparam logic [7:0] RST_HOLDOFF_PERIOD = 8'h80;
	localparam logic [7:0] RST_HOLDOFF_RANGE  = 8'h00;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int PRIO0_LSB    = 6;
	localparam int PRIO1_LSB    = 4;
	localparam int MASK_BIT     = 6;
	localparam int REVERT_BIT   = 5;
	localparam int MODE_LSB     = 2;
	localparam int MSEL_LSB     = 0;
	localparam int PRESCALE_LSB = 6;
	localparam int VCOUNT_LSB   = 0;
	localparam int ST_LATCH_BIT = 0;
	localparam int ST_LIVE_BIT  = 1;
	localparam int ST_SEL_BIT   = 2;
	localparam int ST_NONE_BIT  = 3;
	localparam int ST_LOS_LSB   = 4;

	// ----------------------------------------------------------------
	// encodings and timing
	// ----------------------------------------------------------------
	localparam logic [1:0] PRIO_NEVER  = 2'h0;
	localparam logic [1:0] MSEL_REF1   = 2'h1;
	localparam int         LOS_TIMEOUT = 64;
	localparam int         VALID_EDGES = 4;

	typedef enum logic [2:0]
	{
		ST_NONE_SEL = 3'b001,
		ST_REF0     = 3'b010,
		ST_REF1     = 3'b100
	} sel_state_t;

endpackage

// file: verilog/ref_activity_mon.sv
// Purpose: loss-of-signal monitor for one reference clock pin
// Assumes: reference clock is slower than a quarter of the system clock
// Notes:   re-validation needs a run of edges with no timeout
`timescale 1ns/1ps
module ref_activity_mon
#(
	parameter int TIMEOUT = ref_switch_pkg::LOS_TIMEOUT,
	parameter int EDGES   = ref_switch_pkg::VALID_EDGES
)
(
	input  wire logic       clock,
	input  wire logic       arst_n,
	input  wire logic       ref_pin,
	input  wire logic [1:0] validation_count,
	output logic            los,
	output logic            revalidated
);
	import ref_switch_pkg::*;

	localparam int TW = $clog2(TIMEOUT + 1);
	localparam int EW = $clog2(4 * EDGES + 1);

	// elaboration-time refusal of settings the counters cannot serve
	if (TIMEOUT < 2 || EDGES < 1)
	begin : g_bad_params
		$error("ref_activity_mon: bad parameters");
	end

	logic [2:0]    sync_r;
	logic          level_r;
	logic [TW-1:0] idle_r;
	logic [EW-1:0] edges_r;
	logic          los_r;
	logic          reval_r;

	// ----------------------------------------------------------------
	// filtering and edge detection
	// ----------------------------------------------------------------
	// level moves only when stages two and three agree
	wire           stable   = (sync_r[1] == sync_r[2]);
	wire           rise     = stable && sync_r[2] && !level_r;
	wire           timeout  = (idle_r == TW'(TIMEOUT));
	wire [EW-1:0]  need     = EW'((32'(validation_count) + 32'd1) * 32'(EDGES));
	wire           valid_ok = los_r && rise && (edges_r + EW'(1) >= need);

	// synchroniser and level filter
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			sync_r  <= 3'h0;
			level_r <= 1'b0;
		end
		else
		begin
			sync_r  <= {sync_r[1:0], ref_pin};
			level_r <= stable ? sync_r[2] : level_r;
		end
	end

	// idle timer, edge run and loss flag; starts in loss until proven
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			idle_r  <= '0;
			edges_r <= '0;
			los_r   <= 1'b1;
			reval_r <= 1'b0;
		end
		else
		begin
			idle_r  <= rise ? '0 : (timeout ? idle_r : idle_r + TW'(1));
			reval_r <= valid_ok;
			if (timeout && !rise) // a rise that lands on the deadline still counts as activity
			begin
				los_r   <= 1'b1;
				edges_r <= '0;
			end
			else if (valid_ok)
			begin
				los_r   <= 1'b0;
				edges_r <= '0;
			end
			else if (rise && los_r)
				edges_r <= edges_r + EW'(1);
		end
	end

	assign los         = los_r;
	assign revalidated = reval_r;

endmodule

// file: verilog/reference_input_switch.sv
// Purpose: reference input selection for a dual-input clock conditioner
// Assumes: pll0_unlock is on this clock; pins pass three flip-flops
// Notes:   registers reached by a simple address/strobe port
//
// Operation
// - each input has a 2-bit priority; input zero resets to 11, input one to 10
// - on equal priority automatic selection prefers input zero
// - an input with priority 00 is never picked automatically
// - mask clear: PLL-0 unlock or selected reference loss sets lock status bits
// - mask set: only PLL-0 unlock sets the live and latched lock bits
// - mask set: reference loss raises no GPIO failure indication
// - revertive switching acts only in automatic modes, mode low bit one
// - revertive off: re-validation of a non-selected input changes nothing while the selected input is valid
// - revertive on: re-validation of a non-selected input of higher priority than the selected one triggers a new choice
// - revertive switch only to a strictly higher priority input
// - mode 00 manual, 01 automatic, 10 manual, 11 automatic holdover
// - automatic modes choose from loss states and programmed priorities
// - manual modes: select 00 picks input zero, 01 input one, rest reserved
// - GPIO input clock selection overrides the mode field selection
`timescale 1ns/1ps
module reference_input_switch
#(
	parameter int LOS_TIMEOUT_CYC = ref_switch_pkg::LOS_TIMEOUT,
	parameter int VALID_EDGE_CNT  = ref_switch_pkg::VALID_EDGES
)
(
	input  wire logic       clock,
	input  wire logic       arst_n,
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output logic      [7:0] reg_rdata,
	input  wire logic       ref_clk0,
	input  wire logic       ref_clk1,
	input  wire logic       pll0_unlock,
	input  wire logic       gpio_sel_en,
	input  wire logic       gpio_sel,
	output logic            ref_sel,
	output logic            ref_none,
	output logic            lock_status_live,
	output logic            lock_status_latched,
	output logic            gpio_fail
);
	import ref_switch_pkg::*;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic eligible(input logic [1:0] prio, input logic lost);
		eligible = (prio != PRIO_NEVER) && !lost;
	endfunction

	// best usable input; ties go to input zero
	function automatic sel_state_t best_pick(input logic [1:0] p0, input logic [1:0] p1,
	                                         input logic l0, input logic l1);
		logic e0;
		logic e1;
		e0 = eligible(p0, l0);
		e1 = eligible(p1, l1);
		if (e0 && (!e1 || p0 >= p1))
			best_pick = ST_REF0;
		else if (e1)
			best_pick = ST_REF1;
		else
			best_pick = ST_NONE_SEL;
	endfunction

	logic [7:0] prio_cfg_r;
	logic [7:0] mode_cfg_r;
	logic [7:0] period_cfg_r;
	logic [7:0] range_cfg_r;
	logic [7:0] rdata_r;
	logic [2:0] gsel_en_r;
	logic [2:0] gsel_r;
	logic       gsel_en_f_r;
	logic       gsel_f_r;
	logic       live_r;
	logic       latched_r;
	logic       fail_r;
	sel_state_t state_r;
	sel_state_t state_nxt;
	logic [1:0] los;
	logic [1:0] reval;

	// ----------------------------------------------------------------
	// loss-of-signal monitors
	// ----------------------------------------------------------------
	wire [1:0] ref_pins = {ref_clk1, ref_clk0};

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++)
		begin : g_mon
			ref_activity_mon
			#(
				.TIMEOUT (LOS_TIMEOUT_CYC),
				.EDGES   (VALID_EDGE_CNT)
			)
			u_mon
			(
				.clock            (clock),
				.arst_n           (arst_n),
				.ref_pin          (ref_pins[gi]),
				.validation_count (range_cfg_r[VCOUNT_LSB +: 2]),
				.los              (los[gi]),
				.revalidated      (reval[gi])
			);
		end
	endgenerate

	// ----------------------------------------------------------------
	// configuration fields
	// ----------------------------------------------------------------
	wire [1:0] prio0               = prio_cfg_r[PRIO0_LSB +: 2];
	wire [1:0] prio1               = prio_cfg_r[PRIO1_LSB +: 2];
	wire       ref_loss_lock_mask  = mode_cfg_r[MASK_BIT];
	wire       revertive_switch_en = mode_cfg_r[REVERT_BIT];
	wire [1:0] select_mode         = mode_cfg_r[MODE_LSB +: 2];
	wire [1:0] msel                = mode_cfg_r[MSEL_LSB +: 2];
	wire       auto_mode           = select_mode[0];
	wire       hold_mode           = select_mode[1];

	// ----------------------------------------------------------------
	// selection decode
	// ----------------------------------------------------------------
	// reserved manual codes fall back to input zero
	wire        man_ref1 = (msel == MSEL_REF1);
	sel_state_t man_st;
	assign man_st = man_ref1 ? ST_REF1 : ST_REF0;
	sel_state_t best_st;
	assign best_st = best_pick(prio0, prio1, los[0], los[1]);

	wire       cur_ref1  = (state_r == ST_REF1);
	wire       cur_lost  = (state_r == ST_NONE_SEL) || (cur_ref1 ? los[1] : los[0]);
	wire [1:0] cur_prio  = cur_ref1 ? prio1 : prio0;
	// re-validated input that is not the one in use
	wire       rv0       = reval[0] && (state_r != ST_REF0);
	wire       rv1       = reval[1] && (state_r != ST_REF1);
	wire       up0       = rv0 && eligible(prio0, los[0]) && (prio0 > cur_prio);
	wire       up1       = rv1 && eligible(prio1, los[1]) && (prio1 > cur_prio);
	wire       revert    = auto_mode && revertive_switch_en && (up0 || up1);

	// next selection; without revertive, re-validation alone changes nothing while the selected input is valid
	always_comb
	begin
		state_nxt = state_r;
		case (state_r)
			ST_NONE_SEL, ST_REF0, ST_REF1:
			begin
				if (gsel_en_f_r)
					state_nxt = gsel_f_r ? ST_REF1 : ST_REF0;
				else if (!auto_mode)
					state_nxt = man_st;
				else if (cur_lost)
				begin
					// mode 11 holds the last choice when nothing is usable; mode 01 drops to none
					if (best_st != ST_NONE_SEL || state_r == ST_NONE_SEL || !hold_mode)
						state_nxt = best_st;
				end
				else if (revert)
					state_nxt = best_st;
			end
			default:
				state_nxt = ST_REF0;
		endcase
	end

	// ----------------------------------------------------------------
	// status decode
	// ----------------------------------------------------------------
	wire sel_lost  = cur_ref1 ? los[1] : los[0];
	wire lock_evt  = pll0_unlock || (!ref_loss_lock_mask && sel_lost);
	wire fail_evt  = pll0_unlock || (!ref_loss_lock_mask && sel_lost);
	wire wr_status = reg_wr && (reg_addr == ADDR_SWITCH_STATUS);
	wire clr_latch = wr_status && reg_wdata[ST_LATCH_BIT];

	wire [7:0] status_word = {2'h0, los, (state_r == ST_NONE_SEL), cur_ref1, live_r, latched_r};
	wire [7:0] rd_mux =
		(reg_addr == ADDR_INPUT_PRIORITY) ? {prio_cfg_r[7:4], 4'h0} :
		(reg_addr == ADDR_SWITCH_MODE)    ? {1'b0, mode_cfg_r[6:5], 1'b0, mode_cfg_r[3:0]} :
		(reg_addr == ADDR_HOLDOFF_PERIOD) ? period_cfg_r :
		(reg_addr == ADDR_HOLDOFF_RANGE)  ? {range_cfg_r[7:6], 4'h0, range_cfg_r[1:0]} :
		(reg_addr == ADDR_SWITCH_STATUS)  ? status_word : 8'h00;

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	// configuration writes; reserved bits are stored but read as zero
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			prio_cfg_r   <= RST_INPUT_PRIORITY;
			mode_cfg_r   <= RST_SWITCH_MODE;
			period_cfg_r <= RST_HOLDOFF_PERIOD;
			range_cfg_r  <= RST_HOLDOFF_RANGE;
		end
		else if (reg_wr)
		begin
			if (reg_addr == ADDR_INPUT_PRIORITY)
				prio_cfg_r <= reg_wdata;
			if (reg_addr == ADDR_SWITCH_MODE)
				mode_cfg_r <= reg_wdata;
			if (reg_addr == ADDR_HOLDOFF_PERIOD)
				period_cfg_r <= reg_wdata;
			if (reg_addr == ADDR_HOLDOFF_RANGE)
				range_cfg_r <= reg_wdata;
		end
	end

	// read data, one cycle after the strobe
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
			rdata_r <= 8'h00;
		else if (reg_rd)
			rdata_r <= rd_mux;
	end

	// gpio select pins: three stages, accepted when the last two agree
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			gsel_en_r   <= 3'h0;
			gsel_r      <= 3'h0;
			gsel_en_f_r <= 1'b0;
			gsel_f_r    <= 1'b0;
		end
		else
		begin
			gsel_en_r   <= {gsel_en_r[1:0], gpio_sel_en};
			gsel_r      <= {gsel_r[1:0], gpio_sel};
			gsel_en_f_r <= (gsel_en_r[1] == gsel_en_r[2]) ? gsel_en_r[2] : gsel_en_f_r;
			gsel_f_r    <= (gsel_r[1] == gsel_r[2]) ? gsel_r[2] : gsel_f_r;
		end
	end

	// selection state and lock status; a new event beats the clear
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			state_r   <= ST_REF0;
			live_r    <= 1'b0;
			latched_r <= 1'b0;
			fail_r    <= 1'b0;
		end
		else
		begin
			state_r   <= state_nxt;
			live_r    <= lock_evt;
			latched_r <= lock_evt || (latched_r && !clr_latch);
			fail_r    <= fail_evt;
		end
	end

	assign reg_rdata           = rdata_r;
	assign ref_sel             = cur_ref1;
	assign ref_none            = (state_r == ST_NONE_SEL);
	assign lock_status_live    = live_r;
	assign lock_status_latched = latched_r;
	assign gpio_fail           = fail_r;

endmodule

// file: test/ref_clock_source.sv
// Purpose: two reference clocks feeding the switch, each can be stopped
// Assumes: each half period lasts four system clock cycles
// Notes:   a stopped clock holds its level, as a dead source does
`timescale 1ns/1ps
module ref_clock_source
(
	input  wire logic clock,
	input  wire logic run0,
	input  wire logic run1,
	output logic      ref_clk0 = 1'b0,
	output logic      ref_clk1 = 1'b1
);
	logic [1:0] div_r = 2'h0;

	// ----------------------------------------------------------------
	// clock generation
	// ----------------------------------------------------------------
	// half periods of four cycles keep well above the monitor's sync floor
	always_ff @(posedge clock)
	begin
		div_r <= div_r + 2'h1;
		if (div_r == 2'h3 && run0)
			ref_clk0 <= !ref_clk0;
		if (div_r == 2'h1 && run1)
			ref_clk1 <= !ref_clk1;
	end
endmodule

// file: test/reference_input_switch_properties.sv
// Purpose: port-level properties of the reference input switch
// Assumes: single clock domain, async active-low reset
// Notes:   bound to every instance of the switch
`timescale 1ns/1ps
module ref_switch_checker
(
	input wire logic       clock,
	input wire logic       arst_n,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic       reg_wr,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic       pll0_unlock,
	input wire logic       gpio_sel_en,
	input wire logic       gpio_sel,
	input wire logic       ref_sel,
	input wire logic       lock_status_live,
	input wire logic       lock_status_latched,
	input wire logic       gpio_fail
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!arst_n);

	// mask bit as last written; the design takes it on the same edge
	logic mask_seen_r;
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
			mask_seen_r <= 1'b0;
		else if (reg_wr && reg_addr == 8'h35)
			mask_seen_r <= reg_wdata[6];
	end

	// ----------------------------------------------------------------
	// lock status and failure flag
	// ----------------------------------------------------------------
	a_unlock_sets_live: assert property (pll0_unlock |=> lock_status_live)
		else $error("live lock bit missed an unlock");
	a_live_sets_latch: assert property (lock_status_live |-> lock_status_latched)
		else $error("latched lock bit behind live bit");
	a_latch_stays_set: assert property (lock_status_latched
		&& !(reg_wr && reg_addr == 8'h38 && reg_wdata[0]) |=> lock_status_latched)
		else $error("latched lock bit dropped without clear");
	a_fail_tracks_live: assert property (gpio_fail == lock_status_live)
		else $error("failure flag differs from live lock bit");
	a_masked_no_fail: assert property (mask_seen_r && !pll0_unlock |=> !gpio_fail)
		else $error("failure flag raised while reference loss masked");

	// ----------------------------------------------------------------
	// selection
	// ----------------------------------------------------------------
	// the pin filter is slow, so the gpio input must be quiet beforehand
	a_manual_sel_code: assert property ((!gpio_sel_en)[*8] ##0
		(reg_wr && reg_addr == 8'h35 && !reg_wdata[2])
		|-> ##2 ref_sel == ($past(reg_wdata[1:0], 2) == 2'h1))
		else $error("manual select code not followed");
	a_gpio_picks_one: assert property ((gpio_sel_en && gpio_sel)[*8] |-> ref_sel)
		else $error("gpio override to input one ignored");
	a_gpio_picks_zero: assert property ((gpio_sel_en && !gpio_sel)[*8] |-> !ref_sel)
		else $error("gpio override to input zero ignored");

	// ----------------------------------------------------------------
	// register port
	// ----------------------------------------------------------------
	a_unmapped_read: assert property (reg_rd && (reg_addr < 8'h34 || reg_addr > 8'h38)
		|=> reg_rdata == 8'h00)
		else $error("unmapped address read nonzero");

	c_switch_over: cover property ($rose(ref_sel));
	c_latch_clear: cover property ($fell(lock_status_latched));
	c_fail_raise: cover property ($rose(gpio_fail));
endmodule

bind reference_input_switch ref_switch_checker chk (
	.clock(clock), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pll0_unlock(pll0_unlock),
	.gpio_sel_en(gpio_sel_en), .gpio_sel(gpio_sel), .ref_sel(ref_sel),
	.lock_status_live(lock_status_live), .lock_status_latched(lock_status_latched),
	.gpio_fail(gpio_fail));

// file: test/test_reference_input_switch.sv
// Purpose: self-checking bench for the reference input switch
// Assumes: loss timeout shortened to 16 cycles, one edge per validation step
// Notes:   seeded random fields mixed with fixed corner cases
`timescale 1ns/1ps
module test_reference_input_switch;
	import ref_switch_pkg::*;
	logic       clock = 1'b0;
	logic       arst_n = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic       reg_wr = 1'b0;
	logic       reg_rd = 1'b0;
	logic       pll0_unlock = 1'b0;
	logic       gpio_sel_en = 1'b0;
	logic       gpio_sel = 1'b0;
	logic       run0 = 1'b1;
	logic       run1 = 1'b1;
	logic [7:0] reg_rdata;
	logic       ref_clk0, ref_clk1, ref_sel, ref_none, live, latched, fail;
	int         err_total = 0;
	int         checks_done = 0;
	integer     seed = 32'h9863;
	logic [1:0] p;

	initial
	begin
		forever #20 clock = !clock;
	end

	ref_clock_source src (.clock(clock), .run0(run0), .run1(run1), .ref_clk0(ref_clk0), .ref_clk1(ref_clk1));
	reference_input_switch #(.LOS_TIMEOUT_CYC(16), .VALID_EDGE_CNT(1)) DUT (
		.clock(clock), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ref_clk0(ref_clk0),
		.ref_clk1(ref_clk1), .pll0_unlock(pll0_unlock), .gpio_sel_en(gpio_sel_en),
		.gpio_sel(gpio_sel), .ref_sel(ref_sel), .ref_none(ref_none), .lock_status_live(live),
		.lock_status_latched(latched), .gpio_fail(fail));

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		checks_done++;
		if (g !== e)
		begin
			$display("[ERR] %s expected %h seen %h", n, e, g);
			err_total++;
		end
	endtask
	// strobes drop on the edge that takes them, so a next call starts one edge later
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clock);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clock);
		reg_rd <= 1'b0;
		#1 chk("reg_rdata", e, reg_rdata);
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	function automatic logic exp_sel(input logic [1:0] s);
		return s == 2'h1;
	endfunction
	function automatic logic [7:0] prio_reg(input logic [1:0] p0, input logic [1:0] p1);
		return {p0, p1, 4'h0};
	endfunction
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// watchdog and main sequence
	// ----------------------------------------------------------------
	initial
	begin
		repeat (20000) @(posedge clock);
		err_total++;
		wrap_up;
	end

	initial
	begin
		repeat (5) @(posedge clock);
		arst_n <= 1'b1;
		rd(8'h34, prio_reg(2'h3, 2'h2));
		rd(8'h35, 8'h00);
		rd(8'h36, RST_HOLDOFF_PERIOD);
		rd(8'h37, RST_HOLDOFF_RANGE);
		wr(8'h50, 8'hff);
		rd(8'h50, 8'h00);
		$display("test reset finished");
		// automatic mode, loss of the preferred input, no revert
		p = 2'($random(seed));
		wr(8'h37, {6'h0, p});
		wr(8'h35, 8'h04);
		cyc(80);
		chk("ref_sel", 1'b0, ref_sel);
		run0 <= 1'b0;
		cyc(40);
		chk("ref_sel", 1'b1, ref_sel);
		run0 <= 1'b1;
		cyc(80);
		chk("ref_sel", 1'b1, ref_sel);
		$display("test auto finished");
		// revertive on, then equal and blocked priorities
		wr(8'h35, 8'h2c);
		run0 <= 1'b0;
		cyc(40);
		run0 <= 1'b1;
		cyc(80);
		chk("ref_sel", 1'b0, ref_sel);
		p = 2'($random(seed));
		if (p == 2'h0)
			p = 2'h1;
		wr(8'h34, prio_reg(p, p));
		run0 <= 1'b0;
		cyc(40);
		chk("ref_sel", 1'b1, ref_sel);
		run0 <= 1'b1;
		cyc(80);
		chk("ref_sel", 1'b1, ref_sel);
		wr(8'h34, prio_reg(2'h0, 2'h3));
		run1 <= 1'b0;
		cyc(40);
		chk("ref_sel", 1'b1, ref_sel);
		// automatic without holdover lets go of the dead input
		wr(8'h35, 8'h04);
		cyc(3);
		chk("ref_none", 1'b1, ref_none);
		run1 <= 1'b1;
		cyc(80);
		chk("ref_none", 1'b0, ref_none);
		chk("ref_sel", 1'b1, ref_sel);
		$display("test revert finished");
		// manual codes with the revertive bit at random
		for (int m = 0; m < 2; m++)
			for (int s = 0; s < 4; s++)
			begin
				p = 2'($random(seed));
				wr(8'h35, {2'h0, p[0], 1'b0, m[0], 1'b0, s[1:0]});
				cyc(3);
				chk("ref_sel", exp_sel(s[1:0]), ref_sel);
			end
		$display("test manual finished");
		// lock status with and without the loss mask
		wr(8'h35, 8'h00);
		run0 <= 1'b0;
		cyc(40);
		chk("live", 1'b1, live);
		chk("gpio_fail", 1'b1, fail);
		wr(8'h35, 8'h40);
		cyc(4);
		chk("live", 1'b0, live);
		chk("gpio_fail", 1'b0, fail);
		chk("latched", 1'b1, latched);
		wr(8'h38, 8'h01);
		rd(8'h38, 8'h10);
		pll0_unlock <= 1'b1;
		cyc(3);
		chk("live", 1'b1, live);
		pll0_unlock <= 1'b0;
		run0 <= 1'b1;
		$display("test lock finished");
		// gpio override over manual select zero
		for (int b = 0; b < 2; b++)
		begin
			gpio_sel_en <= 1'b1;
			gpio_sel <= b[0];
			cyc(12);
			chk("ref_sel", b[0], ref_sel);
		end
		gpio_sel_en <= 1'b0;
		$display("test gpio finished");
		wrap_up;
	end
endmodule
